// ===== lss_fcc_model.sv
module lss_fcc_model (
    input  wire logic        core_clk,    // system clock
    input  wire logic        rst_n,       // async reset, active low
    input  wire logic        gain_change, // gain change pulse
    input  wire logic [15:0] accel_mg,    // sensed acceleration, mg
    output logic      [7:0]  gain_count,  // gain steps taken
    output logic             gd_s2_sd     // guidance backup stage two shutdown
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gain_count <= 8'h00;
        end else if (gain_change) begin
            gain_count <= gain_count + 8'h01;
        end
    end
    // guidance backup shutdown on low acceleration
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gd_s2_sd <= 1'b0;
        end else if (accel_mg <= lss_pkg::ACC_STAGE2_MG) begin
            gd_s2_sd <= 1'b1;
        end
    end
endmodule // lss_fcc_model

// ===== lss_pkg.sv
// How it works
// [RQ1] each programmer has thirty scheduled time discretes and one acceleration discrete
// [RQ2] each scheduled discrete is a momentary pulse or a held level
// [RQ3] a programmer asserts its acceleration discrete when sensed acceleration drops
// [RQ4] programmers a and b run side by side, b backing up a
// [RQ5] staging timer first issues stage one engine start on sensed deceleration
// [RQ6] after a fixed delay it issues booster separation and clears its time base
// [RQ7] it times from stage separation, issues shroud backup, clears time base again
// [RQ8] one further timed spare discrete follows the shroud backup
// [RQ9] control computer uses the discretes for gains, pitch rates and channels
// [RQ10] ground equipment drives the start discrete that starts both programmers
// [RQ11] each started programmer asserts a run verification discrete
// [RQ12] ignition selects dump level one; booster gain changes advance the other three
// [RQ13] roll done commands pitch rate one; nine more rates are programmable
// [RQ14] near booster end the ordnance bus enable is set and stays on
// [RQ15] staging timer and programmer b each issue engine start at threshold
// [RQ16] a fixed time later both redundantly issue booster separation
// [RQ17] either chamber pressure switch sets shutdown, separation and start together
// [RQ18] separation connector changes gains and pitch rate, starts timer time base two
// [RQ19] programmer a issues stage two shutdown on acceleration drop
// [RQ20] programmer a issues upper stage separation backup a fixed delay later
// [RQ21] the guidance unit issues its own backup stage two shutdown
// [RQ22] the booster acceleration threshold is 1.5 g
// [RQ23] upper stage separation backup follows stage two shutdown by 7.4 s
// [RQ24] each time base counts fixed ticks; timed discretes compare to constants
// [RQ25] discrete inputs are synchronised and edge detected, acting exactly once
package lss_pkg;

    // ----------------------------------------------------------------
    // clock and time base
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned TICK_NS       = 1000000;     // one time base tick, 1 ms
    localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned TICK_MS       = TICK_NS / 1000000;
    localparam int          DIV_W         = 16;
    localparam int          TB_W          = 20;
    localparam int          NUM_DISC      = 30;

    // ----------------------------------------------------------------
    // schedule of the thirty programmer discretes, in ms from start
    // ----------------------------------------------------------------
    localparam int unsigned           SCHED_BASE_MS = 32'h0000_1388; // 5000 ms
    localparam int unsigned           SCHED_STEP_MS = 32'h0000_3a98; // 15000 ms
    localparam logic [NUM_DISC-1:0]   SCHED_HOLD    = 30'h2aaa_aaaa; // 1 = held level
    localparam int unsigned           GAIN_LO       = 0;             // booster gain slots
    localparam int unsigned           GAIN_HI       = 2;
    localparam int unsigned           PITCH_LO      = 3;             // pitch step slots
    localparam int unsigned           PITCH_HI      = 11;
    localparam logic [3:0]            PITCH_MAX     = 4'ha;          // ten rates

    // ----------------------------------------------------------------
    // fixed times, ms, and their tick counts
    // ----------------------------------------------------------------
    localparam int unsigned ORD_EN_MS      = 32'h0001_24f8;  // 75 s
    localparam int unsigned ACC_EN_B_MS    = 32'h0001_7700;  // 96 s
    localparam int unsigned ACC_EN_A_MS    = 32'h0006_e5a0;  // 452 s
    localparam int unsigned SEP01_MS       = 32'h0000_2ee0;  // 12 s
    localparam int unsigned SHROUD_MS      = 32'h0000_7148;  // 29 s
    localparam int unsigned SPARE_MS       = 32'h0000_2710;  // 10 s
    localparam int unsigned UPPER_SEP_MS   = 32'h0000_1ce8;  // 7.4 s
    localparam logic [TB_W-1:0] ORD_EN_TICKS    = TB_W'(ORD_EN_MS / TICK_MS);
    localparam logic [TB_W-1:0] ACC_EN_B_TICKS  = TB_W'(ACC_EN_B_MS / TICK_MS);
    localparam logic [TB_W-1:0] ACC_EN_A_TICKS  = TB_W'(ACC_EN_A_MS / TICK_MS);
    localparam logic [TB_W-1:0] SEP01_TICKS     = TB_W'(SEP01_MS / TICK_MS);
    localparam logic [TB_W-1:0] SHROUD_TICKS    = TB_W'(SHROUD_MS / TICK_MS);
    localparam logic [TB_W-1:0] SPARE_TICKS     = TB_W'(SPARE_MS / TICK_MS);
    localparam logic [TB_W-1:0] UPPER_SEP_TICKS = TB_W'(UPPER_SEP_MS / TICK_MS);

    // ----------------------------------------------------------------
    // acceleration thresholds, milli-g
    // ----------------------------------------------------------------
    localparam logic [15:0] ACC_STAGE0_MG = 16'h05dc;        // 1.5 g
    localparam logic [15:0] ACC_STAGE2_MG = 16'h03e8;        // 1.0 g

    // ----------------------------------------------------------------
    // staging timer phases and module state
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_TB1  = 3'b001,
        ST_WAIT = 3'b010,
        ST_TB2  = 3'b011,
        ST_TB3  = 3'b100,
        ST_DONE = 3'b101
    } lss_st_phase_t;

    typedef struct packed {
        logic [DIV_W-1:0]    div;
        logic                tick;
        logic [2:0]          start_s;
        logic [2:0]          ign_s;
        logic [2:0]          roll_s;
        logic [2:0]          sep_s;
        logic [2:0]          cps1_s;
        logic [2:0]          cps2_s;
        logic                low_b;
        logic                low_b_d;
        logic                low_a;
        logic                low_a_d;
        logic                run_a;
        logic                run_b;
        logic [TB_W-1:0]     tb_a;
        logic [TB_W-1:0]     tb_b;
        logic [NUM_DISC-1:0] disc_a;
        logic [NUM_DISC-1:0] disc_b;
        logic                acc_a;
        logic                acc_b;
        logic [TB_W-1:0]     tb2_a;
        logic [TB_W-1:0]     tb2_b;
        logic                upper_sep;
        logic                pb_sep01;
        lss_st_phase_t       st_phase;
        logic [TB_W-1:0]     st_tb;
        logic                st_eng_start;
        logic                st_sep01;
        logic                st_shroud;
        logic                st_spare;
        logic                s1_sd;
        logic                s12_sep;
        logic                s2_start;
        logic [1:0]          dump_lvl;
        logic                dump_act;
        logic [3:0]          pitch;
        logic                gain_chg;
        logic                ord_en;
    } lss_state_t;

    localparam lss_state_t STATE_RST = '0;

endpackage

// ===== lss_sequencer.sv
module lss_sequencer #(
    parameter int unsigned TICK_CYCLES = lss_pkg::TICK_CYCLES
) (
    input  wire logic                         core_clk,        // system clock, 50 MHz
    input  wire logic                         rst_n,           // async reset, active low
    input  wire logic                         start_disc,      // ground start discrete
    input  wire logic                         ignition_disc,   // ground booster ignition
    input  wire logic                         roll_done_disc,  // roll maneuver complete
    input  wire logic                         sep_conn_disc,   // stage separation connector
    input  wire logic                         cps_1,           // chamber pressure switch 1
    input  wire logic                         cps_2,           // chamber pressure switch 2
    input  wire logic [15:0]                  accel_mg,        // sensed acceleration, mg
    output logic [lss_pkg::NUM_DISC-1:0]      prog_a_disc,     // programmer a timed
    output logic [lss_pkg::NUM_DISC-1:0]      prog_b_disc,     // programmer b timed
    output logic                              run_verify_a,    // programmer a running
    output logic                              run_verify_b,    // programmer b running
    output logic                              prog_a_accel,    // stage two shutdown
    output logic                              prog_b_accel,    // backup engine start
    output logic                              upper_sep_bu,    // upper stage sep backup
    output logic                              prog_b_sep01,    // booster sep, programmer b
    output logic                              engine_start_st, // engine start, timer
    output logic                              sep01_st,        // booster sep, timer
    output logic                              shroud_bu_st,    // shroud sep backup
    output logic                              spare_st,        // spare timed discrete
    output logic                              s1_shutdown,     // stage one shutdown
    output logic                              s12_separation,  // stage one/two sep
    output logic                              s2_start,        // stage two start
    output logic [1:0]                        dump_level,      // injectant dump level
    output logic                              dump_active,     // dump sequence running
    output logic [3:0]                        pitch_rate,      // selected pitch rate
    output logic                              gain_change,     // gain change pulse
    output logic                              ordnance_bus_en  // ordnance power bus
);

    lss_pkg::lss_state_t q;
    lss_pkg::lss_state_t n;

    logic                         start_evt;
    logic                         ign_evt;
    logic                         roll_evt;
    logic                         sep_evt;
    logic                         cps_evt;
    logic                         drop_b_evt;
    logic                         drop_a_evt;
    logic [lss_pkg::NUM_DISC-1:0] dv_a;
    logic [lss_pkg::NUM_DISC-1:0] dv_b;
    logic [lss_pkg::NUM_DISC-1:0] rise_a;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [lss_pkg::TB_W-1:0] sched_ms(input int unsigned i);
        return lss_pkg::TB_W'((lss_pkg::SCHED_BASE_MS + i * lss_pkg::SCHED_STEP_MS)
                              / lss_pkg::TICK_MS);
    endfunction

    function automatic logic [lss_pkg::NUM_DISC-1:0] disc_vec(
        input logic                    run,
        input logic [lss_pkg::TB_W-1:0] tb
    );
        logic [lss_pkg::NUM_DISC-1:0] v;
        v = '0;
        for (int unsigned i = 0; i < lss_pkg::NUM_DISC; i++) begin
            v[i] = run && (lss_pkg::SCHED_HOLD[i] ? (tb >= sched_ms(i)) : (tb == sched_ms(i)));
        end
        return v;
    endfunction

    function automatic logic [lss_pkg::TB_W-1:0] inc_sat(
        input logic [lss_pkg::TB_W-1:0] tb,
        input logic                     tick
    );
        return (tick && (tb != '1)) ? tb + 1'b1 : tb;
    endfunction

    function automatic logic rise(input logic [2:0] s);
        return s[1] & ~s[2];
    endfunction

    // ----------------------------------------------------------------
    // input events
    // ----------------------------------------------------------------
    // [RQ25] edge after sync
    assign start_evt  = rise(q.start_s);
    assign ign_evt    = rise(q.ign_s);
    assign roll_evt   = rise(q.roll_s);
    assign sep_evt    = rise(q.sep_s);
    assign cps_evt    = rise(q.cps1_s) | rise(q.cps2_s);
    // [RQ3] acceleration drop edges
    assign drop_b_evt = q.low_b & ~q.low_b_d;
    assign drop_a_evt = q.low_a & ~q.low_a_d;
    // [RQ1] scheduled discrete vectors
    assign dv_a   = disc_vec(q.run_a, q.tb_a);
    assign dv_b   = disc_vec(q.run_b, q.tb_b);
    assign rise_a = dv_a & ~q.disc_a;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // tick divider, synchronisers and both programmers
    always_comb begin
        n = q;
        // [RQ24] fixed rate tick
        n.tick = 1'b0;
        if (q.div == lss_pkg::DIV_W'(TICK_CYCLES - 1)) begin
            n.div  = '0;
            n.tick = 1'b1;
        end else begin
            n.div = q.div + 1'b1;
        end
        // [RQ25] two stage sync
        n.start_s = {q.start_s[1:0], start_disc};
        n.ign_s   = {q.ign_s[1:0], ignition_disc};
        n.roll_s  = {q.roll_s[1:0], roll_done_disc};
        n.sep_s   = {q.sep_s[1:0], sep_conn_disc};
        n.cps1_s  = {q.cps1_s[1:0], cps_1};
        n.cps2_s  = {q.cps2_s[1:0], cps_2};
        // [RQ22] booster threshold
        n.low_b   = accel_mg <= lss_pkg::ACC_STAGE0_MG;
        n.low_b_d = q.low_b;
        n.low_a   = accel_mg <= lss_pkg::ACC_STAGE2_MG;
        n.low_a_d = q.low_a;

        // [RQ4] both programmers start
        if (start_evt) begin
            n.run_a = 1'b1;
            n.run_b = 1'b1;
            n.tb_a  = '0;
            n.tb_b  = '0;
        end else begin
            n.tb_a = q.run_a ? inc_sat(q.tb_a, q.tick) : q.tb_a;
            n.tb_b = q.run_b ? inc_sat(q.tb_b, q.tick) : q.tb_b;
        end
        // [RQ2] pulse or held level
        n.disc_a = dv_a;
        n.disc_b = dv_b;

        // [RQ15] programmer b engine start
        if (drop_b_evt && q.run_b && !q.acc_b && q.tb_b >= lss_pkg::ACC_EN_B_TICKS) begin
            n.acc_b = 1'b1;
            n.tb2_b = '0;
        end else if (q.acc_b) begin
            n.tb2_b = inc_sat(q.tb2_b, q.tick);
        end
        // [RQ16] programmer b booster sep
        if (q.acc_b && q.tb2_b == lss_pkg::SEP01_TICKS) begin
            n.pb_sep01 = 1'b1;
        end

        // [RQ19] programmer a stage two shutdown
        if (drop_a_evt && q.run_a && !q.acc_a && q.tb_a >= lss_pkg::ACC_EN_A_TICKS) begin
            n.acc_a = 1'b1;
            n.tb2_a = '0;
        end else if (q.acc_a) begin
            n.tb2_a = inc_sat(q.tb2_a, q.tick);
        end
        // [RQ20] delayed upper stage sep
        // [RQ23] 7.4 s after shutdown
        if (q.acc_a && q.tb2_a == lss_pkg::UPPER_SEP_TICKS) begin
            n.upper_sep = 1'b1;
        end

        // staging timer sequence
        case (q.st_phase)
            lss_pkg::ST_IDLE: begin
                // [RQ5] deceleration start
                if (q.ord_en && drop_b_evt) begin
                    n.st_eng_start = 1'b1;
                    n.st_tb        = '0;
                    n.st_phase     = lss_pkg::ST_TB1;
                end
            end
            lss_pkg::ST_TB1: begin
                // [RQ6] sep then clear
                if (q.st_tb == lss_pkg::SEP01_TICKS) begin
                    n.st_sep01 = 1'b1;
                    n.st_tb    = '0;
                    n.st_phase = lss_pkg::ST_WAIT;
                end else begin
                    n.st_tb = inc_sat(q.st_tb, q.tick);
                end
            end
            lss_pkg::ST_WAIT: begin
                // [RQ18] second time base
                if (sep_evt) begin
                    n.st_tb    = '0;
                    n.st_phase = lss_pkg::ST_TB2;
                end
            end
            lss_pkg::ST_TB2: begin
                // [RQ7] shroud backup then clear
                if (q.st_tb == lss_pkg::SHROUD_TICKS) begin
                    n.st_shroud = 1'b1;
                    n.st_tb     = '0;
                    n.st_phase  = lss_pkg::ST_TB3;
                end else begin
                    n.st_tb = inc_sat(q.st_tb, q.tick);
                end
            end
            lss_pkg::ST_TB3: begin
                // [RQ8] spare discrete
                if (q.st_tb == lss_pkg::SPARE_TICKS) begin
                    n.st_spare = 1'b1;
                    n.st_phase = lss_pkg::ST_DONE;
                end else begin
                    n.st_tb = inc_sat(q.st_tb, q.tick);
                end
            end
            lss_pkg::ST_DONE: begin
                n.st_phase = lss_pkg::ST_DONE;
            end
            default: begin
                n.st_phase = lss_pkg::ST_IDLE;
            end
        endcase

        // [RQ17] simultaneous staging set
        if (cps_evt) begin
            n.s1_sd    = 1'b1;
            n.s12_sep  = 1'b1;
            n.s2_start = 1'b1;
        end

        // [RQ12] dump level sequence
        if (ign_evt) begin
            n.dump_act = 1'b1;
            n.dump_lvl = 2'h0;
        end else if (q.dump_act && |rise_a[lss_pkg::GAIN_HI:lss_pkg::GAIN_LO]
                     && q.dump_lvl != 2'h3) begin
            n.dump_lvl = q.dump_lvl + 2'h1;
        end

        // [RQ18] gain change pulse
        n.gain_chg = sep_evt;
        // [RQ13] pitch rate steps
        if (roll_evt && q.pitch == 4'h0) begin
            n.pitch = 4'h1;
        end else if (q.pitch != 4'h0 && q.pitch != lss_pkg::PITCH_MAX
                     && (|rise_a[lss_pkg::PITCH_HI:lss_pkg::PITCH_LO] || sep_evt)) begin
            n.pitch = q.pitch + 4'h1;
        end

        // [RQ14] sticky ordnance bus
        if ((q.run_a && q.tb_a >= lss_pkg::ORD_EN_TICKS)
            || (q.run_b && q.tb_b >= lss_pkg::ORD_EN_TICKS)) begin
            n.ord_en = 1'b1;
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= lss_pkg::STATE_RST;
        end else begin
            q <= n;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // all outputs straight from the state register
    assign prog_a_disc     = q.disc_a;
    assign prog_b_disc     = q.disc_b;
    // [RQ11] run verification
    assign run_verify_a    = q.run_a;
    assign run_verify_b    = q.run_b;
    assign prog_a_accel    = q.acc_a;
    assign prog_b_accel    = q.acc_b;
    assign upper_sep_bu    = q.upper_sep;
    assign prog_b_sep01    = q.pb_sep01;
    assign engine_start_st = q.st_eng_start;
    assign sep01_st        = q.st_sep01;
    assign shroud_bu_st    = q.st_shroud;
    assign spare_st        = q.st_spare;
    assign s1_shutdown     = q.s1_sd;
    assign s12_separation  = q.s12_sep;
    assign s2_start        = q.s2_start;
    assign dump_level      = q.dump_lvl;
    assign dump_active     = q.dump_act;
    assign pitch_rate      = q.pitch;
    assign gain_change     = q.gain_chg;
    assign ordnance_bus_en = q.ord_en;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_cps_fire;
        cps_evt;
    endsequence
    sequence s_stage_set;
        s1_shutdown && s12_separation && s2_start;
    endsequence
    property p_rq17;
        s_cps_fire |=> s_stage_set;
    endproperty
    a_rq17: assert property (p_rq17) else $error("staging set not raised together"); // RQ17

    property p_rq11;
        start_evt |=> run_verify_a && run_verify_b && q.tb_a == '0;
    endproperty
    a_rq11: assert property (p_rq11) else $error("run verify missing after start"); // RQ11

    property p_rq14;
        ordnance_bus_en |=> ordnance_bus_en;
    endproperty
    a_rq14: assert property (p_rq14) else $error("ordnance bus enable dropped"); // RQ14

    sequence s_decel;
        q.st_phase == lss_pkg::ST_IDLE && q.ord_en && drop_b_evt;
    endsequence
    property p_rq5;
        s_decel |=> engine_start_st && q.st_phase == lss_pkg::ST_TB1;
    endproperty
    a_rq5: assert property (p_rq5) else $error("timer engine start missing"); // RQ5

    property p_rq6;
        $rose(sep01_st) |-> q.st_tb == '0 && q.st_phase == lss_pkg::ST_WAIT
                            && $past(q.st_tb) == lss_pkg::SEP01_TICKS;
    endproperty
    a_rq6: assert property (p_rq6) else $error("booster sep timing wrong"); // RQ6

    property p_rq7;
        $rose(shroud_bu_st) |-> q.st_tb == '0 && $past(q.st_tb) == lss_pkg::SHROUD_TICKS;
    endproperty
    a_rq7: assert property (p_rq7) else $error("shroud backup timing wrong"); // RQ7

    property p_rq12;
        ign_evt |=> dump_active && dump_level == 2'h0;
    endproperty
    a_rq12: assert property (p_rq12) else $error("dump level one not selected"); // RQ12

    property p_rq13;
        roll_evt && pitch_rate == 4'h0 |=> pitch_rate == 4'h1;
    endproperty
    a_rq13: assert property (p_rq13) else $error("first pitch rate not commanded"); // RQ13

    property p_rq20;
        $rose(upper_sep_bu) |-> prog_a_accel && $past(q.tb2_a) == lss_pkg::UPPER_SEP_TICKS;
    endproperty
    a_rq20: assert property (p_rq20) else $error("upper sep backup delay wrong"); // RQ20

    property p_rq25;
        start_evt |=> !start_evt;
    endproperty
    a_rq25: assert property (p_rq25) else $error("start edge seen twice"); // RQ25

endmodule // lss_sequencer

// ===== tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, rst_n = 0, start_disc = 0, ignition_disc = 0;
    logic roll_done_disc = 0, sep_conn_disc = 0, cps_1 = 0;
    logic [15:0] accel_mg = 16'h0fa0;
    logic [29:0] pa, pb;
    logic rva, rvb, paa, pba, usb, pbs, est, sst, shr, spr, s1d, s12, s2s, dact, gch, ord;
    logic [1:0] dlv;
    logic [3:0] pit;
    logic [7:0] gcnt;
    logic gsd;
    int bad_count = 0, checks_done = 0, cyc_n = 0, n;
    // clock and hang limit
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) if (++cyc_n == 100000) begin bad_count++; end_of_test(); end
    lss_sequencer #(.TICK_CYCLES(1)) lss_sequencer_i (.core_clk(core_clk), .rst_n(rst_n),
        .start_disc(start_disc), .ignition_disc(ignition_disc), .roll_done_disc(roll_done_disc),
        .sep_conn_disc(sep_conn_disc), .cps_1(cps_1), .cps_2(1'b0), .accel_mg(accel_mg),
        .prog_a_disc(pa), .prog_b_disc(pb), .run_verify_a(rva), .run_verify_b(rvb),
        .prog_a_accel(paa), .prog_b_accel(pba), .upper_sep_bu(usb), .prog_b_sep01(pbs),
        .engine_start_st(est), .sep01_st(sst), .shroud_bu_st(shr), .spare_st(spr),
        .s1_shutdown(s1d), .s12_separation(s12), .s2_start(s2s), .dump_level(dlv),
        .dump_active(dact), .pitch_rate(pit), .gain_change(gch), .ordnance_bus_en(ord));
    lss_fcc_model lss_fcc_model_i (.core_clk(core_clk), .rst_n(rst_n), .gain_change(gch),
        .gain_count(gcnt), .accel_mg(accel_mg), .gd_s2_sd(gsd));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return pa[0];
            1: return pa[1];
            2: return ord;
            3: return est;
            default: return sst;
        endcase
    endfunction
    // bounded wait, leaves cycle count in n
    task automatic wait_for(input int s, input int lim, input string name);
        n = 0;
        while (pick(s) !== 1'b1 && n < lim) begin cyc(1); n++; end
        check(name, pick(s), 1'b1);
    endtask
    task automatic end_of_test();
        if (bad_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic t_start();
        @(posedge core_clk) start_disc <= 1'b1;
        cyc(4);
        check("run_a", rva, 1'b1);
        check("run_b", rvb, 1'b1);
    endtask
    task automatic t_early();
        @(posedge core_clk) ignition_disc <= 1'b1;
        roll_done_disc <= 1'b1;
        cyc(6);
        check("dump", {dact, dlv}, 3'b100);
        check("pitch", pit, 4'h1);
        @(posedge core_clk) sep_conn_disc <= 1'b1;
        cyc(3);
        check("gain", gch, 1'b1);
        cyc(1);
        check("gain_pulse", {gch, gcnt}, 9'h001);
        check("pitch2", pit, 4'h2);
    endtask
    task automatic t_cps();
        @(posedge core_clk) cps_1 <= 1'b1;
        cyc(2);
        check("cps_early", {s1d, s12, s2s}, 3'b000);
        cyc(1);
        check("cps", {s1d, s12, s2s}, 3'b111);
    endtask
    task automatic t_slots();
        wait_for(0, 5100, "slot0");
        check("slot0_t", n > 4980, 1'b1);
        cyc(1);
        check("slot0_pulse", pa[0], 1'b0);
        cyc(3);
        check("dump1", dlv, 2'h1);
        wait_for(1, 15100, "slot1");
        cyc(20);
        check("slot1_held", {pa[1], pb[1]}, 2'b11);
        check("acc_total", est, 1'b0);
    endtask
    task automatic t_stage0();
        wait_for(2, 55100, "ord_en");
        @(posedge core_clk) accel_mg <= 16'h05db;
        cyc(0);
        wait_for(3, 8, "eng_start");
        check("b_early", pba, 1'b0);
        wait_for(4, 12100, "sep01");
        check("sep01_t", n > 11990, 1'b1);
        check("shroud", {shr, spr, ord}, 3'b001);
        @(posedge core_clk) accel_mg <= 16'h03e8;
        cyc(3);
        check("guid_sd", {gsd, paa, usb}, 3'b100);
    endtask
    // main sequence
    initial begin
        cyc(8);
        check("rst", {pa, rva, est}, 32'h0);
        check("rst_b", {s1d, dact, pit, ord}, 7'h0);
        rst_n <= 1'b1;
        t_start();
        t_early();
        t_cps();
        t_slots();
        t_stage0();
        end_of_test();
    end
endmodule // tb_top
